// file: fnmc_synth_ctl.sv
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Speed-up is active while the load strobe is high and standby is off.
// - Speed-up multiplies proportional scale by two to the (exponent+1).
// - Speed-up enables integrating pump at boosted scale times ratio.
// - Every strobe triggers speed-up; controller keeps it short if unwanted.
// - Modulus select: 0 gives fifths, 1 gives eighths.
// - Each comparison cycle accumulator adds numerator, overflows on reaching modulus.
// - Overflow makes last down count use high ratio, adding one.
// - Fixed-length compensation gate, magnitude scaled by 3 bit accumulator.
// - Zero numerator clears accumulator, suppressing compensation pulses.
// - Eighths: quarter numerators clear bit 0, half clears bits 1:0.
// - Fractional speed-up scales compensation and drives integrating path.
// - Integrating pumps off outside speed-up; proportional always active.
// - Scale is 8 bit, exponent 2 bit, integral ratio 4 bit.
// - Modulus control is a complementary pair; positive usable alone.
// - Counter loads down length, counts to zero, up, reloads, repeats.
// - Comparison pulse on each reload, once per sum of both lengths.
// - Control high in down count, low in up count.
// - Up length is 8 bit; zero counts as 256.
// - Standby bit high places the synthesiser in standby.
module fnmc_synth_ctl (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Pins from outside the clock domain
    input wire logic i_prescaler_feedback_in,
    input wire logic i_synth_load_strobe,
    // Prescaler control and comparator
    output logic o_modulus_ctl_pos,
    output logic o_modulus_ctl_neg,
    output logic o_compare_pulse,
    // Charge pump settings
    output fnmc_pkg::fnmc_pump_s o_pump,
    output logic o_comp_gate_pulse,
    output logic o_standby
);
    import fnmc_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] fb_sync_r, fb_sync_nxt;
    logic [2:0] ls_sync_r, ls_sync_nxt;
    logic fb_filt_r, fb_filt_nxt;
    logic ls_filt_r, ls_filt_nxt;
    logic fb_edge;

    // Three stages; a level counts once stages two and three agree
    always_comb begin
        fb_sync_nxt = {fb_sync_r[1:0], i_prescaler_feedback_in};
        ls_sync_nxt = {ls_sync_r[1:0], i_synth_load_strobe};
        fb_filt_nxt = fb_filt_r;
        ls_filt_nxt = ls_filt_r;
        if (fb_sync_r[1] == fb_sync_r[2]) begin
            fb_filt_nxt = fb_sync_r[2];
        end
        if (ls_sync_r[1] == ls_sync_r[2]) begin
            ls_filt_nxt = ls_sync_r[2];
        end
    end

    // Rising feedback edge drives all sequencing
    assign fb_edge = (fb_sync_r[1] == fb_sync_r[2]) & fb_sync_r[2] &
                     ~fb_filt_r;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            fb_sync_r <= 3'h0;
            ls_sync_r <= 3'h0;
            fb_filt_r <= 1'b0;
            ls_filt_r <= 1'b0;
        end else begin
            fb_sync_r <= fb_sync_nxt;
            ls_sync_r <= ls_sync_nxt;
            fb_filt_r <= fb_filt_nxt;
            ls_filt_r <= ls_filt_nxt;
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    fnmc_cfg_s cfg_r, cfg_nxt;
    fnmc_chan_s chan_r, chan_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    fnmc_state_e state_r, state_nxt;
    logic [11:0] cnt_r, cnt_nxt;
    logic [2:0] acc_r, acc_nxt;
    logic speed_r, speed_nxt;

    // Writes land in shadow copies; the counter picks them up later
    always_comb begin
        cfg_nxt = cfg_r;
        chan_nxt = chan_r;
        rdata_nxt = 32'h0;
        if (i_wr) begin
            unique case (i_addr)
                FNMC_OFS_CTRL: begin
                    cfg_nxt.fraction_modulus_sel = i_wdata[FNMC_CTRL_FRACTION_MODULUS_SEL];
                    cfg_nxt.frac_en = i_wdata[FNMC_CTRL_FRAC];
                    cfg_nxt.standby = i_wdata[FNMC_CTRL_STBY];
                    cfg_nxt.up_exp = i_wdata[FNMC_CTRL_EXP +: 2];
                    cfg_nxt.k_ratio = i_wdata[FNMC_CTRL_KRAT +: 4];
                end
                FNMC_OFS_PUMP: begin
                    cfg_nxt.prop_scale = i_wdata[7:0];
                end
                FNMC_OFS_CHAN: begin
                    chan_nxt.down_len = i_wdata[FNMC_CHAN_DOWN +: 12];
                    chan_nxt.up_len = i_wdata[FNMC_CHAN_UP +: 8];
                    chan_nxt.numer = i_wdata[FNMC_CHAN_NUM +: 3];
                end
                default: begin
                end
            endcase
        end
        // Unmapped reads return zero
        if (i_rd) begin
            unique case (i_addr)
                FNMC_OFS_CTRL: begin
                    rdata_nxt[FNMC_CTRL_FRACTION_MODULUS_SEL] = cfg_r.fraction_modulus_sel;
                    rdata_nxt[FNMC_CTRL_FRAC] = cfg_r.frac_en;
                    rdata_nxt[FNMC_CTRL_STBY] = cfg_r.standby;
                    rdata_nxt[FNMC_CTRL_EXP +: 2] = cfg_r.up_exp;
                    rdata_nxt[FNMC_CTRL_KRAT +: 4] = cfg_r.k_ratio;
                end
                FNMC_OFS_PUMP: begin
                    rdata_nxt[7:0] = cfg_r.prop_scale;
                end
                FNMC_OFS_CHAN: begin
                    rdata_nxt[FNMC_CHAN_DOWN +: 12] = chan_r.down_len;
                    rdata_nxt[FNMC_CHAN_UP +: 8] = chan_r.up_len;
                    rdata_nxt[FNMC_CHAN_NUM +: 3] = chan_r.numer;
                end
                FNMC_OFS_STAT: begin
                    rdata_nxt[11:0] = cnt_r;
                    rdata_nxt[14:12] = acc_r;
                    rdata_nxt[16] = (state_r == FNMC_ST_DOWN);
                    rdata_nxt[17] = speed_r;
                    rdata_nxt[18] = o_modulus_ctl_pos;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cfg_r <= '{fraction_modulus_sel: 1'b0, frac_en: 1'b0, standby: 1'b0,
                       up_exp: 2'h0, k_ratio: 4'h0,
                       prop_scale: FNMC_RST_SCALE};
            chan_r <= '{down_len: FNMC_RST_DOWN, up_len: FNMC_RST_UP,
                        numer: 3'h0};
            rdata_r <= 32'h0;
        end else begin
            cfg_r <= cfg_nxt;
            chan_r <= chan_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign o_rdata = rdata_r;

    // ------------------------------------------------------------
    // Up/down counter, accumulator and modulus control
    // ------------------------------------------------------------
    fnmc_chan_s act_r, act_nxt;
    logic fraction_modulus_sel_act_r, fraction_modulus_sel_act_nxt;
    logic frac_act_r, frac_act_nxt;
    logic ovf_nxt;
    logic mod_r, mod_nxt;
    logic cmp_r, cmp_nxt;
    logic [8:0] up_eff;
    logic [3:0] acc_sum;
    logic [3:0] modulus;
    logic [2:0] acc_new;
    logic [2:0] numer_new;

    // Zero up length stands for 256
    assign up_eff = (act_r.up_len == 8'h00) ? FNMC_UP_ZERO_AS :
                    {1'b0, act_r.up_len};

    // Values used in the cycle now starting are the freshly latched ones
    assign numer_new = chan_r.numer;
    assign modulus = cfg_r.fraction_modulus_sel ? FNMC_MOD_EIGHTHS :
                     FNMC_MOD_FIFTHS;
    assign acc_sum = {1'b0, acc_r} + {1'b0, numer_new};

    // Accumulator step, taken once per comparison cycle
    always_comb begin
        acc_new = acc_r;
        ovf_nxt = 1'b0;
        if (numer_new == 3'h0) begin
            acc_new = 3'h0;
        end else if (acc_sum >= modulus) begin
            acc_new = 3'(acc_sum - modulus);
            ovf_nxt = 1'b1;
        end else begin
            acc_new = acc_sum[2:0];
        end
        if (cfg_r.fraction_modulus_sel && numer_new[0] == 1'b0) begin
            if (numer_new[1]) begin
                acc_new[0] = 1'b0;
            end else begin
                acc_new[1:0] = 2'h0;
            end
        end
    end

    // Sequence advances only on feedback edges, held in standby
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        act_nxt = act_r;
        fraction_modulus_sel_act_nxt = fraction_modulus_sel_act_r;
        frac_act_nxt = frac_act_r;
        acc_nxt = acc_r;
        cmp_nxt = 1'b0;
        if (cfg_r.standby) begin
            state_nxt = FNMC_ST_DOWN;
            cnt_nxt = chan_r.down_len;
            act_nxt = chan_r;
            acc_nxt = 3'h0;
        end else if (fb_edge) begin
            unique case (state_r)
                FNMC_ST_DOWN: begin
                    if (cnt_r <= 12'h001) begin
                        state_nxt = FNMC_ST_UP;
                        cnt_nxt = 12'h000;
                    end else begin
                        cnt_nxt = cnt_r - 12'h001;
                    end
                end
                FNMC_ST_UP: begin
                    if ({3'h0, cnt_r[8:0]} + 12'h001 >=
                        {3'h0, up_eff}) begin
                        state_nxt = FNMC_ST_DOWN;
                        cnt_nxt = chan_r.down_len;
                        act_nxt = chan_r;
                        fraction_modulus_sel_act_nxt = cfg_r.fraction_modulus_sel;
                        frac_act_nxt = cfg_r.frac_en;
                        acc_nxt = cfg_r.frac_en ? acc_new : 3'h0;
                        cmp_nxt = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r + 12'h001;
                    end
                end
                default: begin
                    state_nxt = FNMC_ST_DOWN;
                    cnt_nxt = chan_r.down_len;
                end
            endcase
        end
    end

    // Overflow flag is kept for the whole down period that follows
    logic ovf_hold_r, ovf_hold_nxt;
    always_comb begin
        ovf_hold_nxt = ovf_hold_r;
        if (cfg_r.standby) begin
            ovf_hold_nxt = 1'b0;
        end else if (cmp_nxt) begin
            ovf_hold_nxt = cfg_r.frac_en & ovf_nxt;
        end
    end

    // Control follows next state, so it moves right after the edge
    always_comb begin
        mod_nxt = (state_nxt == FNMC_ST_DOWN);
        if (state_nxt == FNMC_ST_DOWN && cnt_nxt == 12'h001 &&
            ovf_hold_nxt) begin
            mod_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_r <= FNMC_ST_DOWN;
            cnt_r <= FNMC_RST_DOWN;
            act_r <= '{down_len: FNMC_RST_DOWN, up_len: FNMC_RST_UP,
                       numer: 3'h0};
            fraction_modulus_sel_act_r <= 1'b0;
            frac_act_r <= 1'b0;
            acc_r <= 3'h0;
            ovf_hold_r <= 1'b0;
            mod_r <= 1'b1;
            cmp_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            act_r <= act_nxt;
            fraction_modulus_sel_act_r <= fraction_modulus_sel_act_nxt;
            frac_act_r <= frac_act_nxt;
            acc_r <= acc_nxt;
            ovf_hold_r <= ovf_hold_nxt;
            mod_r <= mod_nxt;
            cmp_r <= cmp_nxt;
        end
    end

    // Complementary pair from one flop pair, positive usable alone
    logic modn_r;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            modn_r <= 1'b0;
        end else begin
            modn_r <= ~mod_nxt;
        end
    end

    assign o_modulus_ctl_pos = mod_r;
    assign o_modulus_ctl_neg = modn_r;
    assign o_compare_pulse = cmp_r;

    // ------------------------------------------------------------
    // Speed-up, pump scaling and compensation gate
    // ------------------------------------------------------------
    fnmc_pump_s pump_r, pump_nxt;
    logic [3:0] gate_cnt_r, gate_cnt_nxt;
    logic gate_r, gate_nxt;
    logic stby_r, stby_nxt;
    logic [11:0] prop_boost;
    logic [6:0] comp_boost;

    // Speed-up follows the strobe level, every load triggers it
    assign speed_nxt = ls_filt_r & ~cfg_r.standby;

    // Shift by exponent+1 gives the factors 2, 4, 8 or 16
    assign prop_boost = {4'h0, cfg_r.prop_scale} <<
                        ({1'b0, cfg_r.up_exp} + 3'h1);
    assign comp_boost = {4'h0, acc_r} <<
                        ({1'b0, cfg_r.up_exp} + 3'h1);

    always_comb begin
        pump_nxt.prop = {4'h0, cfg_r.prop_scale};
        pump_nxt.integ_en = 1'b0;
        pump_nxt.integ = 16'h0000;
        pump_nxt.comp = frac_act_r ? {4'h0, acc_r} : 7'h00;
        pump_nxt.comp_integ = 11'h000;
        if (speed_r) begin
            pump_nxt.prop = prop_boost;
            pump_nxt.integ_en = 1'b1;
            pump_nxt.integ = 16'({4'h0, prop_boost} *
                                 {12'h000, cfg_r.k_ratio});
            if (frac_act_r) begin
                pump_nxt.comp = comp_boost;
                pump_nxt.comp_integ = 11'({4'h0, comp_boost} *
                                          {7'h00, cfg_r.k_ratio});
            end
        end
    end

    // Gate of fixed length from the local clock, none for a zero value
    always_comb begin
        gate_cnt_nxt = gate_cnt_r;
        gate_nxt = 1'b0;
        if (cmp_r && frac_act_r && acc_r != 3'h0) begin
            gate_cnt_nxt = FNMC_COMP_GATE_CYC;
        end else if (gate_cnt_r != 4'h0) begin
            gate_cnt_nxt = gate_cnt_r - 4'h1;
        end
        if (gate_cnt_nxt != 4'h0) begin
            gate_nxt = 1'b1;
        end
        stby_nxt = cfg_r.standby;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            speed_r <= 1'b0;
            pump_r <= '0;
            gate_cnt_r <= 4'h0;
            gate_r <= 1'b0;
            stby_r <= 1'b0;
        end else begin
            speed_r <= speed_nxt;
            pump_r <= pump_nxt;
            gate_cnt_r <= gate_cnt_nxt;
            gate_r <= gate_nxt;
            stby_r <= stby_nxt;
        end
    end

    assign o_pump = pump_r;
    assign o_comp_gate_pulse = gate_r;
    assign o_standby = stby_r;

endmodule
`default_nettype wire

// file: fnmc_pkg.sv
package fnmc_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------
    localparam logic [7:0] FNMC_OFS_CTRL = 8'h00;
    localparam logic [7:0] FNMC_OFS_PUMP = 8'h04;
    localparam logic [7:0] FNMC_OFS_CHAN = 8'h08;
    localparam logic [7:0] FNMC_OFS_STAT = 8'h0C;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FNMC_CTRL_FRACTION_MODULUS_SEL = 0;   // fraction_modulus_sel
    localparam int FNMC_CTRL_FRAC = 1;   // fractional mode enable
    localparam int FNMC_CTRL_STBY = 2;   // main_standby_bit
    localparam int FNMC_CTRL_EXP = 4;    // speed-up exponent, 2 bit
    localparam int FNMC_CTRL_KRAT = 8;   // integral gain ratio, 4 bit
    localparam int FNMC_CHAN_DOWN = 0;   // down_count_length, 12 bit
    localparam int FNMC_CHAN_UP = 12;    // up_count_length, 8 bit
    localparam int FNMC_CHAN_NUM = 20;   // fraction_numerator, 3 bit

    // ------------------------------------------------------------
    // Widths, moduli and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] FNMC_MOD_FIFTHS = 4'h5;
    localparam logic [3:0] FNMC_MOD_EIGHTHS = 4'h8;
    localparam logic [8:0] FNMC_UP_ZERO_AS = 9'h100;
    localparam logic [11:0] FNMC_RST_DOWN = 12'h003;
    localparam logic [7:0] FNMC_RST_UP = 8'h01;
    localparam logic [7:0] FNMC_RST_SCALE = 8'h01;

    // ------------------------------------------------------------
    // Timing: compensation gate length from the 50 MHz clock
    // ------------------------------------------------------------
    localparam int FNMC_CLK_PERIOD_NS = 20;
    localparam int FNMC_COMP_GATE_NS = 100;
    localparam int FNMC_COMP_GATE_CYC_I =
        (FNMC_COMP_GATE_NS / FNMC_CLK_PERIOD_NS < 1) ? 1 :
        FNMC_COMP_GATE_NS / FNMC_CLK_PERIOD_NS;
    localparam logic [3:0] FNMC_COMP_GATE_CYC =
        4'(FNMC_COMP_GATE_CYC_I);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FNMC_ST_DOWN = 2'b01,
        FNMC_ST_UP = 2'b10
    } fnmc_state_e;

    typedef struct packed {
        logic fraction_modulus_sel;
        logic frac_en;
        logic standby;
        logic [1:0] up_exp;
        logic [3:0] k_ratio;
        logic [7:0] prop_scale;
    } fnmc_cfg_s;

    typedef struct packed {
        logic [11:0] down_len;
        logic [7:0] up_len;
        logic [2:0] numer;
    } fnmc_chan_s;

    typedef struct packed {
        logic [11:0] prop;
        logic integ_en;
        logic [15:0] integ;
        logic [6:0] comp;
        logic [10:0] comp_integ;
    } fnmc_pump_s;

endpackage

// file: fnmc_synth_ctl_props.sv
`timescale 1ns/10ps
`default_nettype none
module fnmc_synth_ctl_props (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Observed pins
    input wire logic i_synth_load_strobe,
    input wire logic o_modulus_ctl_pos,
    input wire logic o_modulus_ctl_neg,
    input wire logic o_compare_pulse,
    input wire fnmc_pkg::fnmc_pump_s o_pump,
    input wire logic o_comp_gate_pulse,
    input wire logic o_standby
);
    import fnmc_pkg::*;
    // ------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_mod_pair;
        o_modulus_ctl_neg == !o_modulus_ctl_pos;
    endproperty
    a_mod_pair: assert property (p_mod_pair)
        else $error("modulus pair not complementary");
    property p_cmp_single;
        o_compare_pulse |=> !o_compare_pulse;
    endproperty
    a_cmp_single: assert property (p_cmp_single)
        else $error("compare pulse longer than one clock");
    property p_cmp_down;
        o_compare_pulse |-> o_modulus_ctl_pos;
    endproperty
    a_cmp_down: assert property (p_cmp_down)
        else $error("reload without low ratio selected");
    property p_speed_on;
        $rose(i_synth_load_strobe) |-> ##[2:8] o_pump.integ_en;
    endproperty
    a_speed_on: assert property (p_speed_on)
        else $error("speed-up did not start");
    property p_speed_off;
        $fell(i_synth_load_strobe) |-> ##[2:8] !o_pump.integ_en;
    endproperty
    a_speed_off: assert property (p_speed_off)
        else $error("speed-up did not end");
    // Prop and enable switch in the same clock, yet the check looks one cycle in
    property p_prop_even;
        o_pump.integ_en && $past(o_pump.integ_en) |-> !o_pump.prop[0];
    endproperty
    a_prop_even: assert property (p_prop_even)
        else $error("boosted scale not a power-of-two multiple");
    property p_integ_off;
        !o_pump.integ_en |-> o_pump.integ == '0 && o_pump.comp_integ == '0;
    endproperty
    a_integ_off: assert property (p_integ_off)
        else $error("integrating pump active outside speed-up");
    property p_gate_len;
        $rose(o_comp_gate_pulse) |->
            o_comp_gate_pulse [*5] ##1 !o_comp_gate_pulse;
    endproperty
    a_gate_len: assert property (p_gate_len)
        else $error("compensation gate length wrong");
    property p_gate_cause;
        $rose(o_comp_gate_pulse) |-> $past(o_compare_pulse);
    endproperty
    a_gate_cause: assert property (p_gate_cause)
        else $error("compensation gate without reload");
    property p_stby_quiet;
        o_standby && $past(o_standby, 6) |-> !o_compare_pulse;
    endproperty
    a_stby_quiet: assert property (p_stby_quiet)
        else $error("reload while in standby");

    // Main scenarios reached
    c_gate: cover property ($rose(o_comp_gate_pulse));
    c_comp_boost: cover property (o_pump.comp_integ != '0);
    c_standby: cover property ($rose(o_standby));
endmodule

bind fnmc_synth_ctl fnmc_synth_ctl_props u_props (
    .i_clk(i_clk), .i_rst(i_rst), .i_synth_load_strobe(i_synth_load_strobe),
    .o_modulus_ctl_pos(o_modulus_ctl_pos),
    .o_modulus_ctl_neg(o_modulus_ctl_neg), .o_compare_pulse(o_compare_pulse),
    .o_pump(o_pump), .o_comp_gate_pulse(o_comp_gate_pulse),
    .o_standby(o_standby));
`default_nettype wire

// file: fnmc_prescaler_model.sv
`timescale 1ns/10ps
`default_nettype none
module fnmc_prescaler_model #(
    parameter int LOW = 8,
    parameter int HIGH = 9
) (
    // Clock standing in for the oscillator
    input wire logic i_clk,
    // Modulus control, positive leg only
    input wire logic i_mod_pos,
    // Divided output
    output logic o_fb
);
    int cnt = 0;
    int len = LOW;

    initial o_fb = 1'b0;
    // Ratio taken late in the period so the control has time to settle
    always @(posedge i_clk) begin
        if (cnt == LOW - 1) len = i_mod_pos ? LOW : HIGH;
        cnt = (cnt >= len - 1) ? 0 : cnt + 1;
        o_fb <= (cnt < LOW / 2);
    end
endmodule
`default_nettype wire

// file: fracn_synth_modulus_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module fracn_synth_modulus_control_tb_top;
    import fnmc_pkg::*;
    // ------------------------------------------------------------
    // Stimulus, design and prescaler
    // ------------------------------------------------------------
    localparam int LOW = 8;
    localparam int HIGH = 9;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h00000000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_synth_load_strobe = 1'b0;
    logic fb, mod_pos, mod_neg, cmp, gate, stby;
    logic [31:0] o_rdata;
    fnmc_pump_s o_pump;
    int n_errors = 0;
    int num_checks = 0;
    int cnt = 0;
    int last = 0;
    int gaps[$];
    int acc = 0;
    int exp_gap = -1;
    int ex = 0;
    int kr = 0;
    int tn[7] = '{3, 0, 5, 2, 6, 4, 0};
    int tf[7] = '{0, 0, 1, 1, 1, 1, 1};

    always #10 i_clk = ~i_clk;

    fnmc_synth_ctl uut (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_prescaler_feedback_in(fb),
        .i_synth_load_strobe(i_synth_load_strobe),
        .o_modulus_ctl_pos(mod_pos), .o_modulus_ctl_neg(mod_neg),
        .o_compare_pulse(cmp), .o_pump(o_pump), .o_comp_gate_pulse(gate),
        .o_standby(stby));
    fnmc_prescaler_model #(.LOW(LOW), .HIGH(HIGH)) u_presc (
        .i_clk(i_clk), .i_mod_pos(mod_pos), .o_fb(fb));

    // Gap in clocks between compare pulses; old value seen at the edge
    always @(posedge i_clk) begin
        cnt++;
        if (cmp === 1'b1) begin
            gaps.push_back(cnt - last);
            last = cnt;
        end
    end

    task automatic chk(input logic [31:0] got, exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_gap(input int got, exp);
        num_checks++;
        if (got != exp) begin
            n_errors++;
            $display("BAD %0t reload gap %0d exp %0d", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Register port: one-cycle strobes, data in the following cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic next_gap(output int g);
        int t;
        t = 0;
        while (gaps.size() == 0 && t < 40000) begin
            @(posedge i_clk);
            t++;
        end
        if (gaps.size() == 0) begin
            n_errors++;
            $display("BAD %0t no compare pulse", $time);
            g = -1;
        end else begin
            g = gaps.pop_front();
        end
    endtask

    // Reference accumulator and period, stepped at each reload
    task automatic step(input int nm, fm, fr, n1, n2);
        int m, s, ov;
        m = fm ? 8 : 5;
        s = acc + nm;
        ov = (fr != 0 && s >= m) ? 1 : 0;
        if (fr != 0) begin
            acc = s - ov * m;
            if (nm == 0) acc = 0;
            if (fm != 0 && (nm == 2 || nm == 6)) acc = acc & 6;
            if (fm != 0 && nm == 4) acc = acc & 4;
        end
        exp_gap = n1 * LOW + (n2 == 0 ? 256 : n2) * HIGH + ov * (HIGH - LOW);
    endtask

    // Writes land just after a reload, so they apply at the next one
    task automatic run_case(input int n1, n2, nm, fm, fr, reps);
        int g, c;
        logic [31:0] d;
        if (exp_gap < 0) begin
            gaps.delete();
            next_gap(g);
        end
        wr(FNMC_OFS_CTRL, 32'(fm + 2 * fr + 16 * ex + 256 * kr));
        wr(FNMC_OFS_CHAN, 32'(n1 + 4096 * n2 + 1048576 * nm));
        for (int i = 0; i < reps; i++) begin
            next_gap(g);
            if (exp_gap >= 0) chk_gap(g, exp_gap);
            step(nm, fm, fr, n1, n2);
            if (fr != 0) begin
                rd(FNMC_OFS_STAT, d);
                chk(32'(d[14:12]), 32'(acc), "acc");
                c = i_synth_load_strobe ? acc << (ex + 1) : acc;
                chk(32'(o_pump.comp), 32'(c), "comp");
                c = i_synth_load_strobe ? c * kr : 0;
                chk(32'(o_pump.comp_integ), 32'(c), "comp integ");
                chk(32'(gate), 32'(acc != 0), "gate");
                chk(32'(mod_neg), 32'(!mod_pos), "pair");
            end
        end
    endtask

    // Pump scaling, normal and boosted, one exponent per call
    task automatic pump_case(input int e);
        int sc, p;
        sc = (e == 3) ? 255 : $urandom_range(254, 1);
        kr = (e == 3) ? 15 : $urandom_range(14, 1);
        ex = e;
        wr(FNMC_OFS_PUMP, 32'(sc));
        wr(FNMC_OFS_CTRL, 32'(16 * ex + 256 * kr));
        repeat (3) @(posedge i_clk);
        #1 chk(32'(o_pump.prop), 32'(sc), "prop idle");
        chk(32'(o_pump.integ_en), 32'h00000000, "integ idle");
        i_synth_load_strobe <= 1'b1;
        repeat (10) @(posedge i_clk);
        p = sc << (ex + 1);
        #1 chk(32'(o_pump.prop), 32'(p), "prop boost");
        chk(32'(o_pump.integ), 32'(p * kr), "integ boost");
        i_synth_load_strobe <= 1'b0;
        repeat (10) @(posedge i_clk);
        #1 chk(32'(o_pump.prop), 32'(sc), "prop after");
    endtask

    // Main sequence
    initial begin
        logic [31:0] d;
        void'($urandom(32'hF9D6));
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(FNMC_OFS_CTRL, d);
        chk(d, 32'h00000000, "ctrl reset");
        rd(FNMC_OFS_PUMP, d);
        chk(d, 32'h00000001, "pump reset");
        rd(FNMC_OFS_CHAN, d);
        chk(d, 32'h00001003, "chan reset");
        wr(8'h10, 32'hFFFFFFFF);
        rd(8'h10, d);
        chk(d, 32'h00000000, "unmapped");
        for (int e = 0; e < 4; e++) pump_case(e);
        run_case(3, 0, 0, 0, 0, 2);
        run_case(40 - HIGH, LOW, 0, 0, 0, 2);
        for (int i = 0; i < 7; i++) begin
            if (i == 4) i_synth_load_strobe <= 1'b1;
            run_case($urandom_range(40, 3), $urandom_range(30, 1), tn[i],
                tf[i], 1, 4);
            i_synth_load_strobe <= 1'b0;
        end
        wr(FNMC_OFS_CTRL, 32'h00000004);
        repeat (20) @(posedge i_clk);
        gaps.delete();
        repeat (300) @(posedge i_clk);
        #1 chk(32'(stby), 32'h00000001, "standby");
        chk(32'(gaps.size()), 32'h00000000, "held");
        wr(FNMC_OFS_CTRL, 32'h00000000);
        exp_gap = -1;
        acc = 0;
        run_case(3, 255, 1, 0, 1, 3);
        results();
    end

    // Watchdog far past the expected run length
    initial begin
        #2000000;
        n_errors++;
        $display("BAD %0t watchdog expired", $time);
        results();
    end
endmodule
`default_nettype wire
